/* hdl/ata_pio_host.sv */
// PIO cycle sequencer driving an ATA drive port from queued I/O requests.
// Assumes all inputs, including the drive pins, are synchronous to ref_clk.
`timescale 1ns/1ps
module ata_pio_host
   import ata_pio_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire io_req_t cmd,
   input wire logic legacy_mode,
   input wire io_base_t base0,
   input wire io_base_t base1,
   input wire logic [2:0] pio_mode,
   input wire logic float_n,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic rsp_miss,
   output logic rsp_timeout,
   output logic [1:0] ata_cs_n,
   output logic [2:0] ata_da,
   output logic ata_dior_n,
   output logic ata_diow_n,
   output logic ata_ctrl_oe,
   output logic [7:0] ata_dd_out,
   output logic ata_dd_oe,
   input wire logic [7:0] ata_dd_in,
   input wire logic ata_iordy
);
   localparam int REQ_W = $bits(io_req_t);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   state_t state;
   io_req_t cur;
   io_req_t head;
   pio_timing_t tim;
   decode_t dec;
   logic head_valid;
   logic pop;
   logic [7:0] cnt;
   logic [7:0] tot;
   logic [7:0] wait_limit;
   logic strobe_done;
   logic timeout_hit;
   logic hold_done;
   logic recov_done;
   logic strb_act;

   req_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd),
      .out_valid(head_valid),
      .out_ready(pop),
      .out_data(head)
   );

   // No new cycle starts while the bus floats, so the queue backs up instead
   assign pop = head_valid && (state == ST_IDLE) && float_n;
   assign dec = io_decode(head, legacy_mode, base0, base1);
   assign strb_act = !ata_dior_n || !ata_diow_n;

   // Drive holding ready low past its limit is cut off rather than hanging the host
   assign wait_limit = 8'(tim.active + TB_CYC);
   assign timeout_hit = (cnt >= wait_limit);
   assign strobe_done = (cnt >= tim.active) && (cnt >= tim.ta)
                        && (ata_iordy || timeout_hit);
   assign hold_done = (cnt >= tim.hold);
   // At least one cycle beyond hold also keeps the read turnaround clear
   assign recov_done = (cnt >= tim.recov) && (cnt > tim.hold)
                       && (cnt >= T6Z_CYC) && (tot >= tim.cycle);

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         tot <= 8'h00;
         cur <= '0;
         tim <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (pop && dec.hit)
               begin
                  cur <= head;
                  // Counts assume the 25 ns period; a slower clock only stretches each interval
                  tim <= mode_timing(pio_mode);
                  cnt <= 8'h01;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               if (cnt >= tim.setup)
               begin
                  cnt <= 8'h01;
                  tot <= 8'h01;
                  state <= ST_ACTIVE;
               end
               else
               begin
                  cnt <= cnt + 8'h01;
               end
            end
            ST_ACTIVE:
            begin
               tot <= tot + 8'h01;
               if (strobe_done)
               begin
                  cnt <= 8'h01;
                  state <= ST_HOLD;
               end
               else
               begin
                  cnt <= cnt + 8'h01;
               end
            end
            ST_HOLD:
            begin
               tot <= tot + 8'h01;
               cnt <= cnt + 8'h01;
               if (hold_done)
               begin
                  state <= ST_RECOV;
               end
            end
            ST_RECOV:
            begin
               tot <= tot + 8'h01;
               cnt <= cnt + 8'h01;
               if (recov_done)
               begin
                  state <= ST_IDLE;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Address outputs
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ata_cs_n <= CS_IDLE;
         ata_da <= 3'h0;
      end
      else if (pop && dec.hit)
      begin
         ata_cs_n <= dec.adr.cs_n;
         ata_da <= dec.adr.da;
      end
      else if (state == ST_RECOV && recov_done)
      begin
         ata_cs_n <= CS_IDLE;
      end
   end

   // Strobes
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ata_dior_n <= 1'b1;
         ata_diow_n <= 1'b1;
      end
      else if (state == ST_SETUP && cnt >= tim.setup)
      begin
         ata_dior_n <= cur.write;
         ata_diow_n <= !cur.write;
      end
      else if (state == ST_ACTIVE && strobe_done)
      begin
         ata_dior_n <= 1'b1;
         ata_diow_n <= 1'b1;
      end
   end

   // Write data is driven from address setup until hold ends
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ata_dd_out <= 8'h00;
         ata_dd_oe <= 1'b0;
      end
      else
      begin
         if (pop && dec.hit && head.write)
         begin
            ata_dd_out <= head.wdata;
         end
         if (!float_n)
         begin
            ata_dd_oe <= 1'b0;
         end
         else if (pop && dec.hit)
         begin
            ata_dd_oe <= head.write;
         end
         else if (state == ST_HOLD && hold_done)
         begin
            ata_dd_oe <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ata_ctrl_oe <= 1'b0;
      end
      else
      begin
         ata_ctrl_oe <= float_n;
      end
   end

   // Responses: one pulse per request, decoded or not
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_miss <= 1'b0;
         rsp_timeout <= 1'b0;
         rsp_rdata <= 8'h00;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (pop && !dec.hit)
         begin
            rsp_valid <= 1'b1;
            rsp_miss <= 1'b1;
            rsp_timeout <= 1'b0;
            rsp_rdata <= 8'h00;
         end
         else if (state == ST_ACTIVE && strobe_done)
         begin
            rsp_miss <= 1'b0;
            rsp_timeout <= !ata_iordy;
            rsp_rdata <= cur.write ? 8'h00 : ata_dd_in;
         end
         else if (state == ST_RECOV && recov_done)
         begin
            rsp_valid <= 1'b1;
         end
      end
   end

   // Helper counters for the checks below
   logic [7:0] addr_age;
   logic [7:0] act_len;
   logic [7:0] inact_len;
   logic [7:0] cyc_len;
   logic act_d;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_age <= 8'hFF;
         act_len <= 8'h00;
         inact_len <= 8'hFF;
         cyc_len <= 8'hFF;
         act_d <= 1'b0;
      end
      else
      begin
         act_d <= strb_act;
         addr_age <= (pop && dec.hit) ? 8'h00 : (addr_age == 8'hFF ? addr_age : addr_age + 8'h01);
         act_len <= strb_act ? (act_len == 8'hFF ? act_len : act_len + 8'h01) : 8'h00;
         inact_len <= strb_act ? 8'h00 : (inact_len == 8'hFF ? inact_len : inact_len + 8'h01);
         if (strb_act && !act_d)
         begin
            cyc_len <= 8'h01;
         end
         else
         begin
            cyc_len <= (cyc_len == 8'hFF) ? cyc_len : cyc_len + 8'h01;
         end
      end
   end

   sequence s_strobe_on;
      $rose(strb_act);
   endsequence
   sequence s_strobe_off;
      $fell(strb_act);
   endsequence
   sequence s_stalled;
      state == ST_ACTIVE && cnt >= tim.active && !ata_iordy && !timeout_hit;
   endsequence
   sequence s_cycle_end;
      rsp_valid && !rsp_miss;
   endsequence

   addr_setup_a: assert property (s_strobe_on |-> addr_age >= tim.setup)
      else $error("strobe asserted before address setup elapsed");
   active_width_a: assert property (s_strobe_off |-> act_len >= tim.active)
      else $error("strobe active shorter than pulse width");
   recovery_gap_a: assert property (s_cycle_end |-> inact_len >= tim.recov)
      else $error("strobe recovery too short");
   cycle_total_a: assert property (s_cycle_end |-> cyc_len >= tim.cycle)
      else $error("pio cycle shorter than minimum");
   addr_stable_a: assert property (strb_act |-> $stable(ata_da) && $stable(ata_cs_n))
      else $error("address changed while strobe active");

   addr_hold_a: assert property (s_strobe_off |-> ##1 (ata_cs_n != CS_IDLE)
                                 && $stable(ata_da))
      else $error("address not held after strobe");

   write_data_a: assert property (!ata_diow_n && float_n |-> ata_dd_oe ##1
                                  (ata_dd_oe || !float_n) && $stable(ata_dd_out))
      else $error("write data not held around strobe");

   iordy_wait_a: assert property (s_stalled |=> strb_act)
      else $error("cycle closed while drive not ready");

   float_bus_a: assert property (!float_n |=> !ata_ctrl_oe && !ata_dd_oe)
      else $error("ata outputs driven while floating");

   read_release_a: assert property ($rose(ata_dior_n) |-> !ata_dd_oe ##1 !ata_dd_oe)
      else $error("host drove data during read turnaround");

endmodule

/* hdl/ata_pio_pkg.sv */
// Shared types, timing tables and decode constants for the ATA PIO cycle sequencer.
// Assumes a single 40 MHz ref_clk; every time is given in ns, and all but T3 are turned into cycles here.
package ata_pio_pkg;

   localparam int CLK_PERIOD_NS = 25;
   localparam int NUM_MODES = 5;

   localparam int T0_NS [NUM_MODES] = '{600, 383, 240, 180, 120};
   localparam int T1_NS [NUM_MODES] = '{90, 70, 50, 50, 45};
   localparam int T2_NS [NUM_MODES] = '{290, 290, 290, 80, 70};
   localparam int T2I_NS [NUM_MODES] = '{0, 0, 0, 70, 25};
   localparam int T3_NS [NUM_MODES] = '{60, 45, 30, 30, 20};
   localparam int T4_NS [NUM_MODES] = '{30, 20, 15, 10, 10};
   localparam int T9_NS [NUM_MODES] = '{20, 15, 10, 10, 10};
   localparam int TA_NS = 35;
   localparam int TB_NS = 1250;
   localparam int T6Z_NS = 30;

   // Longest time, so it rounds down
   localparam logic [7:0] TB_CYC = 8'(TB_NS / CLK_PERIOD_NS);
   localparam logic [7:0] T6Z_CYC = 8'((T6Z_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam logic [15:0] LEG_CMD_BASE0 = 16'h01F0;
   localparam logic [15:0] LEG_CTL_ADDR0 = 16'h03F6;
   localparam logic [15:0] LEG_CMD_BASE1 = 16'h0170;
   localparam logic [15:0] LEG_CTL_ADDR1 = 16'h0376;
   localparam logic [2:0] CTL_DA = 3'h6;
   localparam logic [1:0] CS_IDLE = 2'h3;
   localparam logic [1:0] CS_CMD = 2'h2;
   localparam logic [1:0] CS_CTL = 2'h1;
   localparam logic [2:0] MODE_MAX = 3'h4;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD, ST_RECOV} state_t;

   typedef struct packed {
      logic write;
      logic func;
      logic [15:0] addr;
      logic [7:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic [15:0] cmd_base;
      logic [15:0] ctl_addr;
   } io_base_t;

   typedef struct packed {
      logic [1:0] cs_n;
      logic [2:0] da;
   } ata_addr_t;

   typedef struct packed {
      logic hit;
      ata_addr_t adr;
   } decode_t;

   typedef struct packed {
      logic [7:0] setup;
      logic [7:0] active;
      logic [7:0] recov;
      logic [7:0] hold;
      logic [7:0] cycle;
      logic [7:0] ta;
   } pio_timing_t;

   function automatic logic [7:0] ns2cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1)
      begin
         c = 1;
      end
      return 8'(c);
   endfunction

   function automatic pio_timing_t mode_timing(input logic [2:0] mode);
      int m;
      pio_timing_t t;
      m = (mode > MODE_MAX) ? int'(MODE_MAX) : int'(mode);
      t.setup = ns2cyc(T1_NS[m]);
      t.active = ns2cyc(T2_NS[m]);
      t.recov = ns2cyc(T2I_NS[m]);
      t.hold = (T4_NS[m] > T9_NS[m]) ? ns2cyc(T4_NS[m]) : ns2cyc(T9_NS[m]);
      t.cycle = ns2cyc(T0_NS[m]);
      t.ta = ns2cyc(TA_NS);
      return t;
   endfunction

   function automatic decode_t io_decode(input io_req_t r, input logic legacy,
                                         input io_base_t b0, input io_base_t b1);
      decode_t d;
      io_base_t b;
      if (legacy)
      begin
         b.cmd_base = r.func ? LEG_CMD_BASE1 : LEG_CMD_BASE0;
         b.ctl_addr = r.func ? LEG_CTL_ADDR1 : LEG_CTL_ADDR0;
      end
      else
      begin
         b = r.func ? b1 : b0;
      end
      d.hit = 1'b0;
      d.adr.cs_n = CS_IDLE;
      d.adr.da = 3'h0;
      if (r.addr[15:3] == b.cmd_base[15:3])
      begin
         d.hit = 1'b1;
         d.adr.cs_n = CS_CMD;
         d.adr.da = r.addr[2:0];
      end
      else if (r.addr == b.ctl_addr)
      begin
         d.hit = 1'b1;
         d.adr.cs_n = CS_CTL;
         d.adr.da = CTL_DA;
      end
      return d;
   endfunction

endpackage

/* hdl/req_fifo.sv */
// Small synchronous FIFO holding queued I/O requests.
// Assumes DEPTH is a power of two; in_ready is registered.
`timescale 1ns/1ps
module req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_comb
   begin
      next_count = count;
      if (push && !pop)
      begin
         next_count = count + 1'b1;
      end
      else if (pop && !push)
      begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end
      else
      begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
         count <= next_count;
         in_ready <= (next_count < (AW+1)'(DEPTH));
      end
   end
endmodule

/* testbench/ata_drive_model.sv */
// Behavioural drive for the PIO port: byte registers, read data, IORDY wait.
// Assumes host pins are synchronous to ref_clk; wait_cyc comes from the bench.
`timescale 1ns/1ps
module ata_drive_model
   import ata_pio_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [1:0] cs_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic ctrl_oe,
   input wire logic [7:0] dd_out,
   input wire logic dd_oe,
   input wire logic [7:0] wait_cyc,
   output logic [7:0] dd_in,
   output logic iordy
);
   logic [7:0] mem [16];
   logic [7:0] last = 8'h00;
   logic [7:0] cnt = 8'h00;
   logic sel;
   logic strb;
   assign sel = ctrl_oe && (cs_n != CS_IDLE);
   assign strb = sel && !(dior_n && diow_n);
   // Low for wait_cyc cycles from strobe start; above 52 breaks the mode 4 limit on purpose
   assign iordy = !(strb && cnt < wait_cyc);
   // Released bus shows the inverse of the last byte, never a stale copy
   assign dd_in = (sel && !dior_n) ? mem[{cs_n[0], da}] : ~last;
   always @(posedge ref_clk)
   begin
      cnt <= strb ? cnt + 8'h01 : 8'h00;
      if (sel && !diow_n && dd_oe)
      begin
         mem[{cs_n[0], da}] <= dd_out;
      end
      if (sel && !dior_n)
      begin
         last <= dd_in;
      end
   end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the PIO sequencer with a behavioural drive attached.
// Assumes the drive answers on the same 40 MHz clock.
`timescale 1ns/1ps
module testbench import ata_pio_pkg::*;;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   io_req_t cmd = '0;
   logic legacy_mode = 1'b1;
   io_base_t base0 = '0;
   io_base_t base1 = '0;
   logic [2:0] pio_mode = 3'h4;
   logic float_n = 1'b1;
   logic rsp_valid, rsp_miss, rsp_timeout;
   logic [7:0] rsp_rdata, ata_dd_out, ata_dd_in;
   logic [7:0] wait_cyc = 8'h00;
   logic [1:0] ata_cs_n;
   logic [2:0] ata_da;
   logic ata_dior_n, ata_diow_n, ata_ctrl_oe, ata_dd_oe, ata_iordy;
   int failures = 0;
   int samples_checked = 0;
   int rsp_cnt = 0, exp_rsp = 0, m = 4;
   int age_a = 0, age_s = 0, age_r = 999, age_f = 999, age_oe = 0, last_act = 0;
   logic [4:0] pa = 5'h1F, last_a = 5'h1F;
   logic s, ps = 1'b0, poe = 1'b0, pf = 1'b1, wr = 1'b0;

   always #12.5 ref_clk = ~ref_clk;

   ata_pio_host dut (.ref_clk, .arst_n, .cmd_valid, .cmd_ready, .cmd, .legacy_mode,
      .base0, .base1, .pio_mode, .float_n, .rsp_valid, .rsp_rdata, .rsp_miss,
      .rsp_timeout, .ata_cs_n, .ata_da, .ata_dior_n, .ata_diow_n, .ata_ctrl_oe,
      .ata_dd_out, .ata_dd_oe, .ata_dd_in, .ata_iordy);

   ata_drive_model drive (.ref_clk, .cs_n(ata_cs_n), .da(ata_da), .dior_n(ata_dior_n),
      .diow_n(ata_diow_n), .ctrl_oe(ata_ctrl_oe), .dd_out(ata_dd_out), .dd_oe(ata_dd_oe),
      .wait_cyc, .dd_in(ata_dd_in), .iordy(ata_iordy));

   function automatic int cy(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input bit atleast = 0);
      samples_checked++;
      if (atleast ? ((got >= exp) !== 1'b1) : (got !== exp))
      begin
         failures++;
         $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Pin monitor: ages count falling edges since each pin event
   always @(negedge ref_clk)
   begin
      if (arst_n)
      begin
         m = int'(pio_mode);
         age_a++;
         age_s++;
         age_r++;
         age_f++;
         age_oe++;
         s = !(ata_dior_n && ata_diow_n);
         if (rsp_valid)
         begin
            rsp_cnt++;
         end
         if ({ata_cs_n, ata_da} != pa)
         begin
            cmp(ps, 0);
            if (pa[4:3] != CS_IDLE)
            begin
               cmp(age_r, cy(T9_NS[m]), 1);
            end
            age_a = 0;
         end
         if (s && !ps)
         begin
            cmp(age_a, cy(T1_NS[m]), 1);
            cmp(age_r, cy(T2I_NS[m]), 1);
            cmp(age_f, cy(T0_NS[m]), 1);
            age_s = 0;
            age_f = 0;
            last_a = {ata_cs_n, ata_da};
            wr = !ata_diow_n;
         end
         if (!s && ps)
         begin
            cmp(age_s, cy(T2_NS[m]), 1);
            if (wr)
            begin
               cmp(age_oe, cy(T3_NS[m]), 1);
            end
            age_r = 0;
            last_act = age_s;
         end
         if (!ata_dd_oe && poe)
         begin
            cmp(age_r, cy(T4_NS[m]), 1);
         end
         if (ata_dd_oe && !poe)
         begin
            age_oe = 0;
         end
         if (!pf && !float_n)
         begin
            cmp({ata_ctrl_oe, ata_dd_oe}, 0);
         end
         pa = {ata_cs_n, ata_da};
         ps = s;
         poe = ata_dd_oe;
         pf = float_n;
      end
   end

   task automatic push(input logic w, input logic f, input logic [15:0] a, input logic [7:0] d);
      int k;
      k = 0;
      cmd_valid = 1'b1;
      cmd = '{w, f, a, d};
      while (cmd_ready !== 1'b1 && k < 200)
      begin
         @(negedge ref_clk);
         k++;
      end
      cmp(cmd_ready, 1);
      @(negedge ref_clk);
   endtask

   task automatic go(input int n);
      int k;
      k = 0;
      cmd_valid = 1'b0;
      exp_rsp += n;
      while (rsp_cnt < exp_rsp && k < 5000)
      begin
         @(negedge ref_clk);
         k++;
      end
      @(negedge ref_clk);
      cmp(rsp_cnt, exp_rsp);
   endtask

   task automatic xfer(input logic w, input logic f, input logic [15:0] a,
                       input logic [7:0] d, input logic miss);
      push(w, f, a, d);
      go(1);
      cmp(rsp_miss, miss);
      if (!w && !miss)
      begin
         cmp(rsp_rdata, d);
      end
   endtask

   task automatic dec(input logic f, input logic [15:0] a, input logic [4:0] ea);
      last_a = 5'h1F;
      xfer(1, f, a, 8'h33, ea == 5'h1F);
      cmp(last_a, ea);
   endtask

   task automatic t_modes;
      for (int i = 0; i < 5; i++)
      begin
         pio_mode = 3'(i);
         push(1, 0, 16'h01F2, 8'hA0 + 8'(i));
         push(1, 0, 16'h03F6, 8'h50 + 8'(i));
         go(2);
         xfer(0, 0, 16'h01F2, 8'hA0 + 8'(i), 0);
         xfer(0, 0, 16'h03F6, 8'h50 + 8'(i), 0);
      end
      $display("modes test done");
   endtask

   task automatic t_decode;
      dec(0, 16'h01F0, 5'h10);
      dec(0, 16'h01F7, 5'h17);
      dec(0, 16'h03F6, 5'h0E);
      dec(0, 16'h01F8, 5'h1F);
      dec(0, 16'h0170, 5'h1F);
      dec(1, 16'h0175, 5'h15);
      dec(1, 16'h0376, 5'h0E);
      dec(1, 16'h03F6, 5'h1F);
      legacy_mode = 1'b0;
      base0 = '{16'h0C40, 16'h0C4A};
      base1 = '{16'h0D80, 16'h0D8E};
      dec(0, 16'h0C43, 5'h13);
      dec(0, 16'h0C4A, 5'h0E);
      dec(0, 16'h01F0, 5'h1F);
      dec(1, 16'h0D8E, 5'h0E);
      dec(1, 16'h0C40, 5'h1F);
      legacy_mode = 1'b1;
      $display("decode test done");
   endtask

   task automatic t_iordy;
      xfer(1, 0, 16'h01F3, 8'h3C, 0);
      wait_cyc = 8'h0A;
      xfer(0, 0, 16'h01F3, 8'h3C, 0);
      cmp(last_act, 10, 1);
      cmp(rsp_timeout, 0);
      wait_cyc = 8'h3C;
      push(0, 0, 16'h01F3, 8'h00);
      go(1);
      cmp(rsp_timeout, 1);
      cmp(last_act, 50, 1);
      wait_cyc = 8'h00;
      $display("iordy test done");
   endtask

   task automatic t_fill;
      float_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      cmp(ata_ctrl_oe, 0);
      last_a = 5'h1F;
      for (int i = 0; i < 8; i++)
      begin
         push(1, 0, 16'h01F0 + 16'(i), 8'(i));
      end
      cmd_valid = 1'b0;
      repeat (20) @(negedge ref_clk);
      cmp(cmd_ready, 0);
      cmp(rsp_cnt, exp_rsp);
      cmp(last_a, 5'h1F);
      // Drive stalls every cycle while the queue drains
      wait_cyc = 8'h04;
      float_n = 1'b1;
      go(8);
      wait_cyc = 8'h00;
      cmp(cmd_ready, 1);
      xfer(0, 0, 16'h01F5, 8'h05, 0);
      $display("fill test done");
   endtask

   initial
   begin
      repeat (2) @(negedge ref_clk);
      cmp({ata_cs_n, ata_dior_n, ata_diow_n, ata_ctrl_oe, ata_dd_oe, rsp_valid}, 7'h78);
      arst_n = 1'b1;
      @(negedge ref_clk);
      t_modes;
      t_decode;
      t_iordy;
      t_fill;
      end_sim;
   end

   // Tests need under a thousand cycles; 30000 cycles leaves wide margin
   initial
   begin
      #750000;
      failures++;
      end_sim;
   end
endmodule
